// >>> rtl/aci_pkg.sv
// Purpose: shared constants and types for the analog command conditioner
// Assumes: samples arrive as signed counts, full scale = +/- full voltage
// Notes:   all scale factors are fixed point with 8 fraction bits
package aci_pkg;
   // -----------------------------------------------------------------
   // widths and fixed-point positions
   // -----------------------------------------------------------------
   localparam int SAMP_W      = 16;
   localparam int NARROW_W    = 14;
   localparam int VEL_W       = 32;
   localparam int SCALE_SHIFT = 8;
   localparam int COEF_SHIFT  = 16;

   // -----------------------------------------------------------------
   // timing: filter coefficient per hertz of cutoff
   // -----------------------------------------------------------------
   localparam int SAMPLE_RATE_HZ = 16000;
   // 2*pi*2^16 = 411775, rounded to nearest per sample rate
   localparam int COEF_PER_HZ =
      (411775 + SAMPLE_RATE_HZ / 2) / SAMPLE_RATE_HZ;
   localparam logic [16:0] COEF_MAX = 17'h10000;

   // -----------------------------------------------------------------
   // reset values and encodings
   // -----------------------------------------------------------------
   localparam logic signed [15:0] OFFSET_RST = 16'sh0000;
   localparam logic signed [15:0] FILT_RST   = 16'sh0000;
   localparam logic signed [31:0] VEL_RST    = 32'sh00000000;
   localparam logic [1:0]         CH2_FN_FIXED_CURRENT_LIMIT = 2'h2;

   typedef enum logic [1:0] {
      ACI_OP_MODE0 = 2'h0,
      ACI_OP_VEL   = 2'h1,
      ACI_OP_MODE2 = 2'h2,
      ACI_OP_CUR   = 2'h3
   } aci_opmode_t;

   typedef struct packed {
      logic signed [15:0] ch1;
      logic signed [15:0] ch2;
   } aci_samp_t;

   typedef struct packed {
      logic signed [31:0] vel;
      logic signed [15:0] cur;
      logic [15:0]        fixed_current_limit;
   } aci_cmd_t;
endpackage

// >>> rtl/aci_top.sv
// Purpose: offset, deadband, filter, scaling and limiting of analog commands
// Assumes: converter samples arrive on mclk_in with valid/ready
// Notes:   pending sample plus buffered commands two at most together
`timescale 1ns/1ns
module aci_top #(
   parameter bit DUAL_CHAN = 1'b0
) (
   // clock and reset
   input  wire logic                mclk_in,
   input  wire logic                rst_in,
   // converter samples
   input  wire logic                samp_valid_in,
   input  wire aci_pkg::aci_samp_t  samp_in,
   output logic                     samp_ready_out,
   // channel one settings
   input  wire logic [15:0]         chan1_deadband_in,
   input  wire logic [15:0]         chan1_filter_cutoff_in,
   input  wire logic                chan1_offset_wr_in,
   input  wire logic signed [15:0]  chan1_offset_wdata_in,
   input  wire logic                chan1_autozero_cmd_in,
   // channel two settings
   input  wire logic [1:0]          chan2_function_select_in,
   input  wire logic [15:0]         chan2_deadband_in,
   input  wire logic [15:0]         chan2_filter_cutoff_in,
   input  wire logic                chan2_offset_wr_in,
   input  wire logic signed [15:0]  chan2_offset_wdata_in,
   input  wire logic                chan2_autozero_cmd_in,
   input  wire logic [15:0]         chan2_current_scale_in,
   // command path settings
   input  wire aci_pkg::aci_opmode_t opmode_in,
   input  wire logic signed [15:0]  vel_scale_in,
   input  wire logic [15:0]         fixed_current_limit_in,
   input  wire logic [31:0]         accel_limit_in,
   input  wire logic [31:0]         decel_limit_in,
   // status
   output logic signed [15:0]       chan1_offset_volts_out,
   output logic signed [15:0]       chan2_offset_volts_out,
   output logic signed [15:0]       chan1_voltage_readback_out,
   output logic signed [15:0]       chan2_voltage_readback_out,
   output logic [15:0]              effective_current_limit_out,
   // conditioned commands
   output logic                     cmd_valid_out,
   output aci_pkg::aci_cmd_t        cmd_out,
   input  wire logic                cmd_ready_in
);
   import aci_pkg::*;

   // -----------------------------------------------------------------
   // arithmetic helpers
   // -----------------------------------------------------------------
   function automatic logic signed [15:0] sub_sat(
      input logic signed [15:0] a, input logic signed [15:0] b);
      logic signed [16:0] d;
      d = {a[15], a} - {b[15], b};
      if (d > 17'sh07fff) begin
         sub_sat = 16'sh7fff;
      end else if (d < 17'sh18000) begin
         sub_sat = 16'sh8000;
      end else begin
         sub_sat = d[15:0];
      end
   endfunction

   function automatic logic [16:0] mag(input logic signed [15:0] x);
      logic signed [16:0] w;
      w   = {x[15], x};
      mag = x[15] ? 17'(-w) : 17'(w);
   endfunction

   function automatic logic signed [15:0] dband(
      input logic signed [15:0] x, input logic [15:0] db);
      dband = (mag(x) <= {1'b0, db}) ? 16'sh0000 : x;
   endfunction

   function automatic logic [16:0] coef(input logic [15:0] hz);
      logic [31:0] p;
      p    = 32'(hz) * 32'(COEF_PER_HZ);
      coef = (p > 32'(COEF_MAX)) ? COEF_MAX : p[16:0];
   endfunction

   // y moves by a fraction a/2^16 of the error, so it stays between y and x
   function automatic logic signed [15:0] lpf(
      input logic signed [15:0] y, input logic signed [15:0] x,
      input logic [16:0] a);
      logic signed [16:0] e;
      logic signed [34:0] pr;
      logic signed [16:0] s;
      e   = {x[15], x} - {y[15], y};
      pr  = e * $signed({1'b0, a});
      s   = {y[15], y} + pr[32:16];
      lpf = s[15:0];
   endfunction

   // -----------------------------------------------------------------
   // sample intake and normalisation
   // -----------------------------------------------------------------
   logic               acc, push, pop;
   logic               pend_q, pend_d;
   logic [1:0]         cnt_q, cnt_d;
   logic signed [15:0] norm1, norm2, x1, x2, corr1;
   logic [16:0]        coef1, coef2;

   // narrow samples are left aligned so both builds share one scale
   assign norm1 = DUAL_CHAN ? {samp_in.ch1[13:0], 2'b00}
                            : samp_in.ch1;
   assign norm2 = DUAL_CHAN ? {samp_in.ch2[13:0], 2'b00}
                            : 16'sh0000;
   // one pending plus buffered words never exceed two slots
   assign samp_ready_out = ({1'b0, cnt_q} + {2'b00, pend_q}) < 3'h2;
   assign acc  = samp_valid_in && samp_ready_out;
   assign push = pend_q;
   assign pop  = cmd_valid_out && cmd_ready_in;
   assign coef1 = coef(chan1_filter_cutoff_in);
   assign coef2 = coef(chan2_filter_cutoff_in);
   assign corr1 = sub_sat(norm1, chan1_offset_volts_out);
   assign x1 = dband(corr1, chan1_deadband_in);
   assign x2 = dband(sub_sat(norm2, chan2_offset_volts_out),
                     chan2_deadband_in);

   // -----------------------------------------------------------------
   // per-channel offset, readback and filter state
   // -----------------------------------------------------------------
   logic signed [15:0] off1_d, off2_d, raw1_d, raw2_d;
   logic signed [15:0] filt1_q, filt1_d, filt2_q, filt2_d;

   always_comb begin
      off1_d = chan1_offset_volts_out;
      off2_d = chan2_offset_volts_out;
      if (chan1_autozero_cmd_in) begin
         off1_d = chan1_voltage_readback_out;
      end else if (chan1_offset_wr_in) begin
         off1_d = chan1_offset_wdata_in;
      end
      if (!DUAL_CHAN) begin
         off2_d = OFFSET_RST;
      end else if (chan2_autozero_cmd_in) begin
         off2_d = chan2_voltage_readback_out;
      end else if (chan2_offset_wr_in) begin
         off2_d = chan2_offset_wdata_in;
      end
      raw1_d  = acc ? norm1 : chan1_voltage_readback_out;
      raw2_d  = acc ? norm2 : chan2_voltage_readback_out;
      filt1_d = acc ? lpf(filt1_q, x1, coef1) : filt1_q;
      filt2_d = acc ? lpf(filt2_q, x2, coef2) : filt2_q;
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         chan1_offset_volts_out     <= OFFSET_RST;
         chan2_offset_volts_out     <= OFFSET_RST;
         chan1_voltage_readback_out <= FILT_RST;
         chan2_voltage_readback_out <= FILT_RST;
         filt1_q                    <= FILT_RST;
         filt2_q                    <= FILT_RST;
      end else begin
         chan1_offset_volts_out     <= off1_d;
         chan2_offset_volts_out     <= off2_d;
         chan1_voltage_readback_out <= raw1_d;
         chan2_voltage_readback_out <= raw2_d;
         filt1_q                    <= filt1_d;
         filt2_q                    <= filt2_d;
      end
   end

   // -----------------------------------------------------------------
   // command forming, slew limit and current limit
   // -----------------------------------------------------------------
   logic signed [31:0] vel_q, vel_d, vprod;
   logic signed [31:0] target;
   logic signed [32:0] diff;
   logic [31:0]        iprod;
   logic [15:0]        alim, fixed_current_limit_d;
   aci_cmd_t           cmd_d;

   always_comb begin
      vprod  = filt1_q * vel_scale_in;
      target = (opmode_in == ACI_OP_VEL) ? (vprod >>> SCALE_SHIFT)
                                         : VEL_RST;
      diff   = {target[31], target} - {vel_q[31], vel_q};
      vel_d  = vel_q;
      if (push) begin
         if (diff > $signed({1'b0, accel_limit_in})) begin
            vel_d = vel_q + accel_limit_in;
         end else if (diff < -$signed({1'b0, decel_limit_in})) begin
            vel_d = vel_q - decel_limit_in;
         end else begin
            vel_d = target;
         end
      end
      iprod = mag(filt2_q) * chan2_current_scale_in;
      alim  = (|iprod[31:24]) ? 16'hffff : iprod[23:8];
      fixed_current_limit_d = fixed_current_limit_in;
      if (DUAL_CHAN && chan2_function_select_in == CH2_FN_FIXED_CURRENT_LIMIT &&
          alim < fixed_current_limit_in) begin
         fixed_current_limit_d = alim;
      end
      cmd_d.vel  = vel_d;
      cmd_d.cur  = (opmode_in == ACI_OP_CUR) ? filt1_q
                                             : 16'sh0000;
      cmd_d.fixed_current_limit = fixed_current_limit_d;
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         vel_q                       <= VEL_RST;
         effective_current_limit_out <= 16'h0000;
      end else begin
         vel_q                       <= vel_d;
         effective_current_limit_out <= fixed_current_limit_d;
      end
   end

   // -----------------------------------------------------------------
   // two-entry command buffer
   // -----------------------------------------------------------------
   aci_cmd_t mem_q [2];
   aci_cmd_t mem_d [2];
   logic     wp_q, wp_d, rp_q, rp_d;

   always_comb begin
      pend_d   = acc;
      mem_d[0] = mem_q[0];
      mem_d[1] = mem_q[1];
      if (push) begin
         mem_d[wp_q] = cmd_d;
      end
      wp_d  = wp_q ^ push;
      rp_d  = rp_q ^ pop;
      cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         pend_q   <= 1'b0;
         cnt_q    <= 2'h0;
         wp_q     <= 1'b0;
         rp_q     <= 1'b0;
         mem_q[0] <= '0;
         mem_q[1] <= '0;
      end else begin
         pend_q   <= pend_d;
         cnt_q    <= cnt_d;
         wp_q     <= wp_d;
         rp_q     <= rp_d;
         mem_q[0] <= mem_d[0];
         mem_q[1] <= mem_d[1];
      end
   end

   assign cmd_valid_out = cnt_q != 2'h0;
   assign cmd_out       = mem_q[rp_q];

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   // sign-extended velocity so a step of either sign can be measured
   logic signed [32:0] vel_x;
   assign vel_x = {vel_q[31], vel_q};

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   sequence zero_req1;
      chan1_autozero_cmd_in;
   endsequence

   AST_NARROW_CH2: assert property (
      !DUAL_CHAN |-> filt2_q == 16'sh0000 &&
                     chan2_offset_volts_out == 16'sh0000)
      else $error("absent channel two has state");
   AST_OFFSET: assert property (
      acc && chan1_deadband_in == 16'h0000 && coef1 == COEF_MAX
      |=> filt1_q == $past(corr1))
      else $error("offset not removed");
   AST_DEADBAND: assert property (
      acc && mag(sub_sat(norm1, chan1_offset_volts_out))
             <= {1'b0, chan1_deadband_in} |-> x1 == 16'sh0000)
      else $error("deadband input not zeroed");
   AST_FILTER: assert property (
      acc |=> ($past(x1) >= $past(filt1_q))
         ? (filt1_q <= $past(x1) && filt1_q >= $past(filt1_q))
         : (filt1_q >= $past(x1) && filt1_q <= $past(filt1_q)))
      else $error("filter overshoot");
   AST_READBACK: assert property (
      acc |=> chan1_voltage_readback_out == $past(norm1))
      else $error("readback not updated");
   AST_AUTOZERO: assert property (
      zero_req1 |=> chan1_offset_volts_out ==
                    $past(chan1_voltage_readback_out) &&
                    ($past(acc) || sub_sat(chan1_voltage_readback_out,
                     chan1_offset_volts_out) == 16'sh0000))
      else $error("autozero offset wrong");
   AST_FIXED_CURRENT_LIMIT_MIN: assert property (
      1'b1 |=> effective_current_limit_out <=
               $past(fixed_current_limit_in))
      else $error("limit above fixed limit");
   AST_FIXED_CURRENT_LIMIT_FIXED: assert property (
      chan2_function_select_in != CH2_FN_FIXED_CURRENT_LIMIT
      |=> effective_current_limit_out == $past(fixed_current_limit_in))
      else $error("limit ignores function select");
   AST_SLEW: assert property (
      push |=> (vel_x - $past(vel_x))
                  <= $signed({1'b0, $past(accel_limit_in)}) &&
               (vel_x - $past(vel_x))
                  >= -$signed({1'b0, $past(decel_limit_in)}))
      else $error("velocity slew exceeded");
   AST_NO_LOSS: assert property (
      push |-> cnt_q != 2'h2)
      else $error("buffer overflow");
endmodule

// >>> testbench/aci_ctrl_model.sv
// Purpose: motion controller model offering converter samples
// Assumes: a sample stays on the wires until the block takes it or 200 edges pass
// Notes:   idle data is the inverse of the last word, never stale
`timescale 1ns/1ns
module aci_ctrl_model (
   // clock and reset
   input  wire logic          mclk_in,
   input  wire logic          rst_in,
   // sample handshake
   input  wire logic          samp_ready_in,
   output logic               samp_valid_out,
   output aci_pkg::aci_samp_t samp_out
);
   import aci_pkg::*;
   initial begin
      samp_valid_out = 1'b0;
      samp_out       = '0;
   end
   // -----------------------------------------------------------------
   // offer one sample, return after the edge that takes it
   // -----------------------------------------------------------------
   task automatic send(input aci_samp_t s, output bit ok);
      int n;
      n  = 0;
      ok = 1'b0;
      @(posedge mclk_in);
      samp_valid_out <= 1'b1;
      samp_out       <= s;
      while (!ok && n < 200) begin
         @(posedge mclk_in);
         ok = (samp_ready_in === 1'b1);
         n++;
      end
      // released wires must not look like a fresh sample
      samp_valid_out <= 1'b0;
      samp_out       <= ~s;
   endtask
endmodule

// >>> testbench/tb.sv
// Purpose: self-checking bench for the analog command conditioner
// Assumes: dual 14-bit build compared; single 16-bit build status only
// Notes:   slew, limit and buffering checked through the command port
`timescale 1ns/1ns
module tb;
   import aci_pkg::*;
   // -----------------------------------------------------------------
   // signals
   // -----------------------------------------------------------------
   logic               mclk_in = 1'b0, rst_in = 1'b1, cmd_ready_in = 1'b0;
   logic               samp_valid_in, samp_ready_out, cmd_valid_out;
   aci_samp_t          samp_in;
   aci_cmd_t           cmd_out;
   logic [15:0]        chan1_deadband_in = '0, chan2_deadband_in = '0;
   logic [15:0]        chan1_filter_cutoff_in = 16'hffff;
   logic [15:0]        chan2_filter_cutoff_in = 16'hffff;
   logic [15:0]        chan2_current_scale_in = 16'h0100;
   logic [15:0]        fixed_current_limit_in = 16'hffff;
   logic               chan1_offset_wr_in = 1'b0, chan2_offset_wr_in = 1'b0;
   logic               chan1_autozero_cmd_in = 1'b0;
   logic               chan2_autozero_cmd_in = 1'b0;
   logic signed [15:0] chan1_offset_wdata_in = '0, chan2_offset_wdata_in = '0;
   logic signed [15:0] vel_scale_in = 16'sh0100;
   logic [1:0]         chan2_function_select_in = 2'h2;
   aci_opmode_t        opmode_in = ACI_OP_CUR;
   logic [31:0]        accel_limit_in = 32'h00010000;
   logic [31:0]        decel_limit_in = 32'h00010000;
   logic signed [15:0] chan1_offset_volts_out, chan2_offset_volts_out;
   logic signed [15:0] chan1_voltage_readback_out, chan2_voltage_readback_out;
   logic [15:0]        effective_current_limit_out;
   int                 fails = 0, n_checks = 0, cycles = 0;
   aci_cmd_t           c;
   logic signed [15:0] s1_rb, s2_rb, s2_off;
   logic [15:0]        s_lim;

   always #5 mclk_in = ~mclk_in;

   aci_top #(.DUAL_CHAN(1'b1)) aci_top_i (.mclk_in, .rst_in, .samp_valid_in,
      .samp_in, .samp_ready_out, .chan1_deadband_in, .chan1_filter_cutoff_in,
      .chan1_offset_wr_in, .chan1_offset_wdata_in, .chan1_autozero_cmd_in,
      .chan2_function_select_in, .chan2_deadband_in, .chan2_filter_cutoff_in,
      .chan2_offset_wr_in, .chan2_offset_wdata_in, .chan2_autozero_cmd_in,
      .chan2_current_scale_in, .opmode_in, .vel_scale_in,
      .fixed_current_limit_in, .accel_limit_in, .decel_limit_in,
      .chan1_offset_volts_out, .chan2_offset_volts_out,
      .chan1_voltage_readback_out, .chan2_voltage_readback_out,
      .effective_current_limit_out, .cmd_valid_out, .cmd_out, .cmd_ready_in);

   // single build on the same wires; its handshake matches the dual one
   if (1'b1) begin : single
      aci_top #(.DUAL_CHAN(1'b0)) aci_top_i (.mclk_in, .rst_in,
         .samp_valid_in, .samp_in, .samp_ready_out(),
         .chan1_deadband_in, .chan1_filter_cutoff_in, .chan1_offset_wr_in,
         .chan1_offset_wdata_in, .chan1_autozero_cmd_in,
         .chan2_function_select_in, .chan2_deadband_in,
         .chan2_filter_cutoff_in, .chan2_offset_wr_in,
         .chan2_offset_wdata_in, .chan2_autozero_cmd_in,
         .chan2_current_scale_in, .opmode_in, .vel_scale_in,
         .fixed_current_limit_in, .accel_limit_in, .decel_limit_in,
         .chan1_offset_volts_out(), .chan2_offset_volts_out(s2_off),
         .chan1_voltage_readback_out(s1_rb),
         .chan2_voltage_readback_out(s2_rb),
         .effective_current_limit_out(s_lim), .cmd_valid_out(),
         .cmd_out(), .cmd_ready_in);
   end

   aci_ctrl_model aci_ctrl_model_i (.mclk_in, .rst_in,
      .samp_ready_in(samp_ready_out), .samp_valid_out(samp_valid_in),
      .samp_out(samp_in));

   // -----------------------------------------------------------------
   // tasks
   // -----------------------------------------------------------------
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic offs_wr(input bit ch2, input logic signed [15:0] d);
      @(posedge mclk_in);
      if (ch2) chan2_offset_wr_in <= 1'b1;
      else chan1_offset_wr_in <= 1'b1;
      chan1_offset_wdata_in <= d;
      chan2_offset_wdata_in <= d;
      @(posedge mclk_in);
      chan1_offset_wr_in <= 1'b0;
      chan2_offset_wr_in <= 1'b0;
   endtask

   task automatic get_cmd(output aci_cmd_t r);
      int n;
      n = 0;
      @(posedge mclk_in);
      cmd_ready_in <= 1'b1;
      do begin
         @(posedge mclk_in);
         n++;
      end while (cmd_valid_out !== 1'b1 && n < 50);
      r = cmd_out;
      cmd_ready_in <= 1'b0;
      if (n >= 50) begin
         fails++;
         $display("ERROR %0t: no command", $time);
      end
   endtask

   task automatic send(input logic [31:0] s);
      bit ok;
      aci_ctrl_model_i.send(s, ok);
      if (!ok) begin
         fails++;
         $display("ERROR %0t: sample not taken", $time);
      end
   endtask

   task automatic step(input logic [31:0] s, output aci_cmd_t r);
      send(s);
      get_cmd(r);
   endtask

   task automatic set_lim(input logic [15:0] v);
      @(posedge mclk_in);
      fixed_current_limit_in <= v;
      repeat (3) @(posedge mclk_in);
   endtask

   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         $display("ERROR %0t: timeout", $time);
         wrap_up();
      end
   end

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge mclk_in);
      rst_in <= 1'b0;
      // 14-bit count 0x64 normalises to 0x190
      offs_wr(0, 16'sh0028);
      step({16'h0064, 16'h0064}, c);
      chk(chan1_voltage_readback_out, 16'h0190);
      chk(s1_rb, 16'h0064);
      chk(s2_rb, 16'h0000);
      chk(chan1_offset_volts_out, 16'h0028);
      chk(c.cur, 16'h0168);
      chk(c.vel, 32'h00000000);
      @(posedge mclk_in) chan1_deadband_in <= 16'h0168;
      step({16'h0064, 16'h0064}, c);
      chk(c.cur, 16'h0000);
      @(posedge mclk_in) chan1_deadband_in <= 16'h0167;
      step({16'h0064, 16'h0064}, c);
      chk(c.cur, 16'h0168);
      // two samples while the receiver stalls
      @(posedge mclk_in) chan1_deadband_in <= 16'h0000;
      send({16'h0032, 16'h0064});
      send({16'h0064, 16'h0064});
      repeat (2) @(posedge mclk_in);
      chk({samp_ready_out, cmd_valid_out}, 2'h1);
      get_cmd(c);
      chk(c.cur, 16'h00a0);
      get_cmd(c);
      chk(c.cur, 16'h0168);
      // zero command beats a write in the same cycle
      @(posedge mclk_in);
      chan1_autozero_cmd_in <= 1'b1;
      chan1_offset_wr_in    <= 1'b1;
      chan1_offset_wdata_in <= 16'sh0007;
      @(posedge mclk_in);
      chan1_autozero_cmd_in <= 1'b0;
      chan1_offset_wr_in    <= 1'b0;
      @(posedge mclk_in);
      chk(chan1_offset_volts_out, 16'h0190);
      step({16'h0064, 16'h0064}, c);
      chk(c.cur, 16'h0000);
      // channel two as current limit
      set_lim(16'h03e8);
      chk(effective_current_limit_out, 16'h0190);
      chk(s_lim, 16'h03e8);
      step({16'h0064, 16'h0064}, c);
      chk(c.fixed_current_limit, 16'h0190);
      set_lim(16'h012c);
      chk(effective_current_limit_out, 16'h012c);
      @(posedge mclk_in) chan2_function_select_in <= 2'h0;
      set_lim(16'h03e8);
      chk(effective_current_limit_out, 16'h03e8);
      @(posedge mclk_in) chan2_function_select_in <= 2'h2;
      offs_wr(1, 16'sh0064);
      step({16'h0064, 16'h0064}, c);
      repeat (2) @(posedge mclk_in);
      chk(chan2_offset_volts_out, 16'h0064);
      chk(effective_current_limit_out, 16'h012c);
      chk(chan2_voltage_readback_out, 16'h0190);
      @(posedge mclk_in) chan2_autozero_cmd_in <= 1'b1;
      @(posedge mclk_in) chan2_autozero_cmd_in <= 1'b0;
      @(posedge mclk_in);
      chk(chan2_offset_volts_out, 16'h0190);
      chk(s2_off, 16'h0000);
      // velocity mode, scale 2.0, then slew limits
      @(posedge mclk_in);
      opmode_in    <= ACI_OP_VEL;
      vel_scale_in <= 16'sh0200;
      offs_wr(0, 16'sh0000);
      step({16'h0019, 16'h0064}, c);
      chk(c.vel, 32'h000000c8);
      chk(c.cur, 16'h0000);
      @(posedge mclk_in) accel_limit_in <= 32'h0000001e;
      step({16'h0064, 16'h0064}, c);
      chk(c.vel, 32'h000000e6);
      step({16'h0064, 16'h0064}, c);
      chk(c.vel, 32'h00000104);
      @(posedge mclk_in) decel_limit_in <= 32'h00000032;
      step({16'h0000, 16'h0064}, c);
      chk(c.vel, 32'h000000d2);
      // other modes feed neither command; velocity still slews to zero
      @(posedge mclk_in) opmode_in <= ACI_OP_MODE0;
      step({16'h0064, 16'h0064}, c);
      chk(c.cur, 16'h0000);
      chk(c.vel, 32'h000000a0);
      // 1024 Hz gives 26624/65536 of the error: 0x190 moves down by 163
      @(posedge mclk_in);
      opmode_in              <= ACI_OP_CUR;
      chan1_filter_cutoff_in <= 16'h0400;
      step({16'h0000, 16'h0064}, c);
      chk(c.cur, 16'h00ed);
      wrap_up();
   end
endmodule
